/* File: include/chg_params.svh */
`ifndef CHG_PARAMS_SVH
`define CHG_PARAMS_SVH

// Slave address, 7-bit only
`define CHG_I2C_ADDR 7'h6A

// Register pointers
`define CHG_REG_FAULT 8'h01
`define CHG_REG_THERM 8'h02
`define CHG_REG_FAST 8'h03
`define CHG_UNMAPPED_DATA 8'hFF

// Fault register: flags in the high nibble, masks in the low nibble
`define CHG_FLT_MASK_HI 3
`define CHG_FLT_MASK_LO 0
`define CHG_FLT_MASK_RST 4'h0

// Thermistor control register fields
`define CHG_TH_EN_BIT 7
`define CHG_TH_INT_BIT 3
`define CHG_TH_WAKE_BIT 2
`define CHG_TH_RESET_BIT 1
`define CHG_TH_TIMER_BIT 0
`define CHG_TH_EN_RST 1'h1
`define CHG_TH_INT_RST 1'h1
`define CHG_TH_MASK_RST 1'h0

// Fast charge control register fields
`define CHG_FC_RANGE_BIT 7
`define CHG_FC_CODE_HI 6
`define CHG_FC_CODE_LO 2
`define CHG_FC_CE_BIT 1
`define CHG_FC_HZ_BIT 0
`define CHG_FC_RST 8'h14

// Current code limits and scale, currents in mA
`define CHG_CODE_EXT 5'h1F
`define CHG_CODE_MAX_HI 5'h1A
`define CHG_I_BASE_LO 9'h005
`define CHG_I_STEP_LO 9'h001
`define CHG_I_BASE_HI 9'h028
`define CHG_I_STEP_HI 9'h00A

// Cycles after reset release before the strap code is taken
`define CHG_STRAP_WAIT 2'h3

`endif

/* File: include/chg_pkg.sv */
package chg_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WR = 3'b011,
		ST_WR_ACK = 3'b100,
		ST_RD = 3'b101,
		ST_RD_ACK = 3'b110
	} chg_i2c_state_e;

	typedef struct packed {
		logic input_overvoltage;
		logic input_undervoltage;
		logic battery_low_lockout;
		logic battery_overcurrent;
	} chg_fault_s;

	typedef struct packed {
		chg_fault_s faults;
		logic [1:0] temperature_fault_code;
		logic thermistor_open_flag;
		logic wake_event;
		logic reset_event;
		logic timer_fault;
	} chg_status_s;

	typedef struct packed {
		logic [4:0] resistor_code;
		logic [4:0] otp_code;
		logic set_resistor_grounded;
	} chg_strap_s;

	typedef struct packed {
		logic thermistor_monitor_enable;
		logic int_content_all;
		logic charge_current_scale;
		logic [4:0] charge_current_code;
		logic charger_disable;
		logic high_impedance_select;
		logic external_current_select;
		logic [8:0] charge_current_ma;
	} chg_ctrl_s;

	typedef struct packed {
		chg_fault_s faults;
		logic wake;
		logic reset;
		logic timer;
	} chg_event_s;

endpackage : chg_pkg

/* File: rtl/chg_regs_i2c.sv */
// Behaviour
// (RULE1) Input overvoltage flag stays set through reads while the condition lasts.
// (RULE2) Input undervoltage flag sets on dropping below sleep level, clears once read.
// (RULE3) Battery low lockout flag stays set through reads while the condition lasts.
// (RULE4) Battery overcurrent flag latches on the fault, cleared by reading.
// (RULE5) Fault register low nibble: four masks, reset 0, 1 suppresses that fault.
// (RULE6) Thermistor register bit 7 enables thermistor monitoring, resets to 1.
// (RULE7) Read-only two-bit temperature fault code shows the thermistor state.
// (RULE8) Read-only open-thermistor flag reads 1 when the thermistor is disconnected.
// (RULE9) Interrupt content bit, reset 1: faults plus status, else faults only.
// (RULE10) Wake mask bit set suppresses push-button wake events; resets to 0.
// (RULE11) Reset mask bit set suppresses push-button reset events; resets to 0.
// (RULE12) Timer mask bit set suppresses safety timer faults; resets to 0.
// (RULE13) Scale bit picks 5 mA + code*1 mA or 40 mA + code*10 mA.
// (RULE14) Five-bit current code sits in bits 6..2, binary weighted.
// (RULE15) Written codes above range maximum saturate to 35 mA or 300 mA.
// (RULE16) All-ones code is not clamped and selects the resistor-set current.
// (RULE17) Host programs termination bits before writing the all-ones current code.
// (RULE18) Charger disable bit: 0 charges (reset value), 1 disables.
// (RULE19) High impedance bit: 1 enters high impedance mode, resets to 0.
// (RULE20) Power-up current code comes from set resistor, or from OTP when grounded.
// (RULE21) Fault and mask register sits at pointer 0x01.
// (RULE22) Serial slave answers only to seven-bit address 6A.
// (RULE23) Reads of unmapped pointers return 0xFF.
// (RULE24) Read-clear flags clear only after the byte has fully gone out.
`timescale 1ns/10ps
`include "chg_params.svh"
module chg_regs_i2c (
	input wire logic core_clk, // 20 MHz system clock
	input wire logic resetn, // Async reset, active low
	input wire logic scl_in, // Serial clock pin
	input wire logic sda_in, // Serial data pin level
	output logic sda_out, // Serial data drive value
	output logic sda_oe, // Serial data drive enable
	input chg_pkg::chg_status_s status_in, // Analog status, asynchronous
	input chg_pkg::chg_strap_s strap_in, // Current straps, asynchronous
	output chg_pkg::chg_ctrl_s ctrl_out, // Register controls
	output chg_pkg::chg_event_s event_out // Masked events
);
	import chg_pkg::*;

	localparam int STW = $bits(chg_status_s) + $bits(chg_strap_s);

	logic [1:0] bus_s;
	logic [STW-1:0] pins_s;
	chg_status_s st;
	chg_strap_s strap;
	logic scl_s, sda_s, scl_q, sda_q;
	logic scl_rise, scl_fall, start_c, stop_c;

	chg_i2c_state_e state;
	logic [2:0] bit_cnt;
	logic [7:0] sh, ptr, rd_mux, next_byte;
	logic first, rw, ack_ph, nack, drive_low;
	logic wr_stb;
	logic [7:0] wr_addr, wr_data;
	logic rd_clr;
	logic [3:0] snap;
	logic ptr_unmapped;

	chg_fault_s flt_flag, flt_mask, cond_q, set_bits, clr_bits;
	logic uv_rise, ocp_rise;
	logic therm_en, int_all, wake_m, reset_m, timer_m;
	logic rng, ce, hz;
	logic [4:0] code, wr_code, next_code;
	logic [1:0] strap_cnt;
	logic strap_done, strap_ld;
	logic [8:0] cur_ma;
	logic ext_sel;
	chg_event_s evt;

	// Serial pins are asynchronous; two flops before any decoding
	chg_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_bus_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.d_in({scl_in, sda_in}),
		.q_out(bus_s)
	);

	chg_sync #(.WIDTH(STW), .RST_VAL({STW{1'b0}})) u_pin_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.d_in({status_in, strap_in}),
		.q_out(pins_s)
	);

	assign {st, strap} = pins_s;
	assign scl_s = bus_s[1];
	assign sda_s = bus_s[0];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_c = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
	assign next_byte = {sh[6:0], sda_s};

	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe = drive_low;

	always_comb begin
		if (ptr == `CHG_REG_FAULT) begin // [RULE21]
			rd_mux = {flt_flag, flt_mask};
		end else if (ptr == `CHG_REG_THERM) begin
			rd_mux = {therm_en, st.temperature_fault_code, st.thermistor_open_flag, // [RULE7] [RULE8]
				int_all, wake_m, reset_m, timer_m};
		end else if (ptr == `CHG_REG_FAST) begin
			rd_mux = {rng, code, ce, hz}; // [RULE14]
		end else begin
			rd_mux = `CHG_UNMAPPED_DATA; // [RULE23]
		end
	end

	assign ptr_unmapped = (ptr != `CHG_REG_FAULT) && (ptr != `CHG_REG_THERM) && (ptr != `CHG_REG_FAST);

	// Serial slave; bits sampled on SCL rise, data changed on SCL fall
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			bit_cnt <= 3'h0;
			sh <= 8'h00;
			ptr <= 8'h00;
			first <= 1'b0;
			rw <= 1'b0;
			ack_ph <= 1'b0;
			nack <= 1'b0;
			drive_low <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			rd_clr <= 1'b0;
			snap <= 4'h0;
		end else begin
			wr_stb <= 1'b0;
			rd_clr <= 1'b0;
			if (start_c) begin
				state <= ST_ADDR;
				bit_cnt <= 3'h0;
				first <= 1'b1;
				ack_ph <= 1'b0;
				drive_low <= 1'b0;
			end else if (stop_c) begin
				state <= ST_IDLE;
				ack_ph <= 1'b0;
				drive_low <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					ST_ADDR, ST_WR: begin
						sh <= next_byte;
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7 && state == ST_ADDR) begin
							if (next_byte[7:1] == `CHG_I2C_ADDR) begin // [RULE22]
								rw <= next_byte[0];
								state <= ST_ADDR_ACK;
							end else begin
								state <= ST_IDLE;
							end
						end else if (bit_cnt == 3'h7) begin
							state <= ST_WR_ACK;
							if (first) begin
								ptr <= next_byte;
								first <= 1'b0;
							end else begin
								wr_stb <= 1'b1;
								wr_addr <= ptr;
								wr_data <= next_byte;
								ptr <= ptr + 8'h01;
							end
						end
					end
					ST_RD: begin
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							state <= ST_RD_ACK;
						end
					end
					ST_RD_ACK: begin
						// Ninth clock: byte fully out, safe to clear what it showed
						if (ack_ph) begin
							nack <= sda_s;
							rd_clr <= (ptr == `CHG_REG_FAULT); // [RULE24]
							ptr <= ptr + 8'h01;
						end
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state)
					ST_ADDR_ACK, ST_WR_ACK: begin
						if (!ack_ph) begin
							drive_low <= 1'b1;
							ack_ph <= 1'b1;
						end else if (state == ST_ADDR_ACK && rw) begin
							ack_ph <= 1'b0;
							sh <= rd_mux;
							snap <= rd_mux[7:4];
							drive_low <= ~rd_mux[7];
							bit_cnt <= 3'h0;
							state <= ST_RD;
						end else begin
							ack_ph <= 1'b0;
							drive_low <= 1'b0;
							bit_cnt <= 3'h0;
							state <= ST_WR;
						end
					end
					ST_RD: begin
						sh <= {sh[6:0], 1'b0};
						drive_low <= ~sh[6];
					end
					ST_RD_ACK: begin
						if (!ack_ph) begin
							drive_low <= 1'b0;
							ack_ph <= 1'b1;
						end else if (nack) begin
							ack_ph <= 1'b0;
							state <= ST_IDLE;
						end else begin
							ack_ph <= 1'b0;
							sh <= rd_mux;
							snap <= rd_mux[7:4];
							drive_low <= ~rd_mux[7];
							bit_cnt <= 3'h0;
							state <= ST_RD;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Fault flags; a set in the clearing cycle wins
	assign uv_rise = st.faults.input_undervoltage & ~cond_q.input_undervoltage;
	assign ocp_rise = st.faults.battery_overcurrent & ~cond_q.battery_overcurrent;
	assign set_bits = {st.faults.input_overvoltage, uv_rise, st.faults.battery_low_lockout, ocp_rise};
	// Only bits that were actually shown are cleared
	assign clr_bits = rd_clr ? snap : 4'h0; // [RULE24]

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cond_q <= 4'h0;
			flt_flag <= 4'h0;
		end else begin
			cond_q <= st.faults;
			flt_flag <= set_bits | (flt_flag & ~clr_bits); // [RULE1] [RULE2] [RULE3] [RULE4]
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			flt_mask <= `CHG_FLT_MASK_RST;
		end else if (wr_stb && wr_addr == `CHG_REG_FAULT) begin
			flt_mask <= wr_data[`CHG_FLT_MASK_HI:`CHG_FLT_MASK_LO]; // [RULE5]
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			therm_en <= `CHG_TH_EN_RST;
			int_all <= `CHG_TH_INT_RST;
			wake_m <= `CHG_TH_MASK_RST;
			reset_m <= `CHG_TH_MASK_RST;
			timer_m <= `CHG_TH_MASK_RST;
		end else if (wr_stb && wr_addr == `CHG_REG_THERM) begin
			therm_en <= wr_data[`CHG_TH_EN_BIT]; // [RULE6]
			int_all <= wr_data[`CHG_TH_INT_BIT]; // [RULE9]
			wake_m <= wr_data[`CHG_TH_WAKE_BIT];
			reset_m <= wr_data[`CHG_TH_RESET_BIT];
			timer_m <= wr_data[`CHG_TH_TIMER_BIT];
		end
	end

	// Strap taken once the pin synchroniser has settled after release
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			strap_cnt <= 2'h0;
			strap_done <= 1'b0;
		end else if (strap_cnt != `CHG_STRAP_WAIT) begin
			strap_cnt <= strap_cnt + 2'h1;
		end else begin
			strap_done <= 1'b1;
		end
	end

	assign strap_ld = (strap_cnt == `CHG_STRAP_WAIT) && !strap_done;

	// Low-range ceiling equals code 30, so only the high range can overflow
	assign wr_code = wr_data[`CHG_FC_CODE_HI:`CHG_FC_CODE_LO];
	always_comb begin
		if (wr_data[`CHG_FC_RANGE_BIT] && wr_code != `CHG_CODE_EXT && wr_code > `CHG_CODE_MAX_HI) begin
			next_code = `CHG_CODE_MAX_HI; // [RULE15]
		end else begin
			next_code = wr_code; // [RULE16]
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rng <= 1'(`CHG_FC_RST >> `CHG_FC_RANGE_BIT);
			code <= 5'(`CHG_FC_RST >> `CHG_FC_CODE_LO);
			ce <= 1'(`CHG_FC_RST >> `CHG_FC_CE_BIT);
			hz <= 1'(`CHG_FC_RST >> `CHG_FC_HZ_BIT);
		end else if (strap_ld) begin
			code <= strap.set_resistor_grounded ? strap.otp_code : strap.resistor_code; // [RULE20]
		end else if (wr_stb && wr_addr == `CHG_REG_FAST) begin
			rng <= wr_data[`CHG_FC_RANGE_BIT];
			code <= next_code;
			ce <= wr_data[`CHG_FC_CE_BIT]; // [RULE18]
			hz <= wr_data[`CHG_FC_HZ_BIT]; // [RULE19]
		end
	end

	// Registered outputs: current in mA and masked events
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cur_ma <= 9'h000;
			ext_sel <= 1'b0;
		end else begin
			cur_ma <= rng ? `CHG_I_BASE_HI + {4'h0, code} * `CHG_I_STEP_HI
				: `CHG_I_BASE_LO + {4'h0, code} * `CHG_I_STEP_LO; // [RULE13]
			ext_sel <= (code == `CHG_CODE_EXT); // [RULE16]
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			evt <= '0;
		end else begin
			evt.faults <= flt_flag & ~flt_mask; // [RULE5]
			evt.wake <= st.wake_event & ~wake_m; // [RULE10]
			evt.reset <= st.reset_event & ~reset_m; // [RULE11]
			evt.timer <= st.timer_fault & ~timer_m; // [RULE12]
		end
	end

	assign event_out = evt;
	assign ctrl_out.thermistor_monitor_enable = therm_en;
	assign ctrl_out.int_content_all = int_all;
	assign ctrl_out.charge_current_scale = rng;
	assign ctrl_out.charge_current_code = code;
	assign ctrl_out.charger_disable = ce;
	assign ctrl_out.high_impedance_select = hz;
	assign ctrl_out.external_current_select = ext_sel;
	assign ctrl_out.charge_current_ma = cur_ma;

	property p_ov_hold;
		@(posedge core_clk) disable iff (!resetn)
		st.faults.input_overvoltage && rd_clr |=> flt_flag.input_overvoltage;
	endproperty
	a_ov_hold: assert property (p_ov_hold) else $error("overvoltage flag lost on read"); // [RULE1]

	property p_uv_clear;
		@(posedge core_clk) disable iff (!resetn)
		rd_clr && clr_bits.input_undervoltage && !uv_rise |=> !flt_flag.input_undervoltage
			##1 (!flt_flag.input_undervoltage || $past(uv_rise));
	endproperty
	a_uv_clear: assert property (p_uv_clear) else $error("undervoltage flag not cleared by read"); // [RULE2]

	property p_uvlo_hold;
		@(posedge core_clk) disable iff (!resetn)
		st.faults.battery_low_lockout |=> flt_flag.battery_low_lockout;
	endproperty
	a_uvlo_hold: assert property (p_uvlo_hold) else $error("lockout flag dropped"); // [RULE3]

	property p_ocp_cycle;
		@(posedge core_clk) disable iff (!resetn)
		ocp_rise |=> flt_flag.battery_overcurrent ##1 (evt.faults.battery_overcurrent == !$past(flt_mask.battery_overcurrent));
	endproperty
	a_ocp_cycle: assert property (p_ocp_cycle) else $error("overcurrent not latched or masked wrongly"); // [RULE4]

	property p_mask_write;
		@(posedge core_clk) disable iff (!resetn)
		wr_stb && wr_addr == `CHG_REG_FAULT |=> flt_mask == $past(wr_data[3:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("fault mask write not taken"); // [RULE5]

	property p_keep_unshown;
		@(posedge core_clk) disable iff (!resetn)
		rd_clr && !clr_bits.battery_overcurrent && flt_flag.battery_overcurrent |=> flt_flag.battery_overcurrent;
	endproperty
	a_keep_unshown: assert property (p_keep_unshown) else $error("unread overcurrent event lost"); // [RULE24]

	property p_clamp_hi;
		@(posedge core_clk) disable iff (!resetn)
		wr_stb && wr_addr == `CHG_REG_FAST && !strap_ld && wr_data[7] && wr_code > `CHG_CODE_MAX_HI
			&& wr_code != `CHG_CODE_EXT |=> code == `CHG_CODE_MAX_HI ##1 cur_ma == 9'h12C;
	endproperty
	a_clamp_hi: assert property (p_clamp_hi) else $error("high range code not saturated"); // [RULE15]

	property p_ext_sel;
		@(posedge core_clk) disable iff (!resetn)
		code == `CHG_CODE_EXT |=> ext_sel;
	endproperty
	a_ext_sel: assert property (p_ext_sel) else $error("all-ones code did not select external"); // [RULE16]

	property p_unmapped;
		@(posedge core_clk) disable iff (!resetn)
		$rose(state == ST_RD) && $past(ptr_unmapped) |-> sh == `CHG_UNMAPPED_DATA;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0xFF"); // [RULE23]

	property p_addr_miss;
		@(posedge core_clk) disable iff (!resetn)
		scl_rise && state == ST_ADDR && bit_cnt == 3'h7 && next_byte[7:1] != `CHG_I2C_ADDR
			|=> state == ST_IDLE && !sda_oe;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged"); // [RULE22]

endmodule : chg_regs_i2c

/* File: rtl/chg_sync.sv */
`timescale 1ns/10ps
module chg_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic core_clk, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic [WIDTH-1:0] d_in, // Asynchronous inputs
	output logic [WIDTH-1:0] q_out // Synchronised outputs
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			meta <= RST_VAL;
			q_out <= RST_VAL;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule : chg_sync

/* File: test/chg_i2c_master.sv */
`timescale 1ns/10ps
module chg_i2c_master (
	input wire logic core_clk, // System clock
	input wire logic dev_sda_oe, // Device pulls data low
	input wire logic dev_sda_out, // Device drive value
	output logic scl, // Serial clock to device
	output logic sda_line // Resolved data wire
);
	localparam int HALF = 6;
	logic m_oe;
	// Pull-up on the wire: released means high, never a stale value
	assign sda_line = ~(m_oe | (dev_sda_oe & ~dev_sda_out));
	initial begin
		scl = 1'b1;
		m_oe = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wait_clk
	// Also serves as repeated start
	task automatic bus_start();
		wait_clk(2);
		m_oe <= 1'b0;
		wait_clk(HALF);
		scl <= 1'b1;
		wait_clk(HALF);
		m_oe <= 1'b1;
		wait_clk(HALF);
		scl <= 1'b0;
	endtask : bus_start
	task automatic bus_stop();
		wait_clk(2);
		m_oe <= 1'b1;
		wait_clk(HALF);
		scl <= 1'b1;
		wait_clk(HALF);
		m_oe <= 1'b0;
		wait_clk(HALF);
	endtask : bus_stop
	// Data moves two cycles after the clock fall to keep hold time
	task automatic xfer_bit(input logic b, output logic s);
		wait_clk(2);
		m_oe <= ~b;
		wait_clk(HALF);
		scl <= 1'b1;
		wait_clk(HALF / 2);
		@(negedge core_clk);
		s = sda_line;
		wait_clk(HALF / 2);
		scl <= 1'b0;
	endtask : xfer_bit
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(b[i], s);
		end
		xfer_bit(1'b1, s);
		ack = ~s;
	endtask : send_byte
	task automatic recv_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b1, b[i]);
		end
		xfer_bit(nack, s);
	endtask : recv_byte
	task automatic wr(input logic [7:0] addr_byte, input logic [7:0] ptr, input logic [7:0] data, output logic ok);
		logic a0;
		logic a1;
		logic a2;
		bus_start();
		send_byte(addr_byte, a0);
		send_byte(ptr, a1);
		send_byte(data, a2);
		bus_stop();
		ok = a0 & a1 & a2;
	endtask : wr
	task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
		logic a0;
		logic a1;
		logic a2;
		bus_start();
		send_byte(8'hD4, a0);
		send_byte(ptr, a1);
		bus_start();
		send_byte(8'hD5, a2);
		recv_byte(1'b1, d);
		bus_stop();
		ok = a0 & a1 & a2;
	endtask : rd
endmodule : chg_i2c_master

/* File: test/chg_regs_i2c_tb.sv */
`timescale 1ns/10ps
`include "chg_params.svh"
module charger_fault_mask_charge_ctrl_regs_tb_top;
	import chg_pkg::*;
	logic core_clk;
	logic resetn;
	logic scl_in;
	logic sda_in;
	logic sda_out;
	logic sda_oe;
	chg_status_s status_in;
	chg_strap_s strap_in;
	chg_ctrl_s ctrl_out;
	chg_event_s event_out;
	int failures;
	int checks_done;

	chg_regs_i2c dut (.core_clk(core_clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .status_in(status_in), .strap_in(strap_in),
		.ctrl_out(ctrl_out), .event_out(event_out));
	chg_i2c_master m (.core_clk(core_clk), .dev_sda_oe(sda_oe), .dev_sda_out(sda_out), .scl(scl_in),
		.sda_line(sda_in));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
		logic ok;
		m.wr(8'hD4, ptr, data, ok);
		check("write ack", 16'h0001, ok);
	endtask : wr
	task automatic rd_chk(input string name, input logic [7:0] ptr, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		m.rd(ptr, d, ok);
		check("read ack", 16'h0001, ok);
		check(name, exp, d);
	endtask : rd_chk
	task automatic do_reset();
		@(posedge core_clk);
		resetn <= 1'b0;
		cyc(10);
		resetn <= 1'b1;
		cyc(8);
	endtask : do_reset

	task automatic t_reset_values();
		logic ok;
		for (int g = 0; g < 2; g++) begin
			strap_in.set_resistor_grounded <= (g != 0);
			do_reset();
			check("monitor enable", 16'h0001, ctrl_out.thermistor_monitor_enable);
			check("int content", 16'h0001, ctrl_out.int_content_all);
			check("strap code", (g != 0) ? 16'h000C : 16'h0009, ctrl_out.charge_current_code);
			check("charger disable", 16'h0000, ctrl_out.charger_disable);
			check("high impedance", 16'h0000, ctrl_out.high_impedance_select);
		end
		rd_chk("fault reg reset", `CHG_REG_FAULT, 8'h00);
		rd_chk("fast reg strap", `CHG_REG_FAST, 8'h30);
		for (int c = 0; c < 4; c++) begin
			status_in.temperature_fault_code <= c[1:0];
			status_in.thermistor_open_flag <= c[0];
			cyc(6);
			rd_chk("therm reg", `CHG_REG_THERM, {1'b1, c[1:0], c[0], 4'h8});
		end
		rd_chk("unmapped 00", 8'h00, `CHG_UNMAPPED_DATA);
		rd_chk("unmapped 04", 8'h04, `CHG_UNMAPPED_DATA);
		rd_chk("unmapped FF", 8'hFF, `CHG_UNMAPPED_DATA);
		m.wr(8'hD6, `CHG_REG_FAST, 8'h9C, ok);
		check("foreign address ack", 16'h0000, ok);
		check("foreign address write", 16'h0000, ctrl_out.charge_current_scale);
	endtask : t_reset_values

	task automatic t_faults();
		@(posedge core_clk);
		status_in.faults <= 4'hF;
		cyc(6);
		status_in.faults <= 4'hA;
		cyc(6);
		rd_chk("flags all set", `CHG_REG_FAULT, 8'hF0);
		rd_chk("flags after read", `CHG_REG_FAULT, 8'hA0);
		status_in.faults <= 4'h0;
		cyc(6);
		rd_chk("flags latched", `CHG_REG_FAULT, 8'hA0);
		rd_chk("flags cleared", `CHG_REG_FAULT, 8'h00);
		status_in.faults <= 4'h4;
		cyc(6);
		rd_chk("new undervoltage", `CHG_REG_FAULT, 8'h40);
		// Condition still present: a read must not bring the flag back
		rd_chk("undervoltage once", `CHG_REG_FAULT, 8'h00);
		status_in.faults <= 4'h0;
	endtask : t_faults

	task automatic t_masks();
		logic [2:0] mb;
		@(posedge core_clk);
		status_in.faults <= 4'hF;
		status_in.wake_event <= 1'b1;
		status_in.reset_event <= 1'b1;
		status_in.timer_fault <= 1'b1;
		cyc(6);
		check("fault events", 16'h000F, event_out.faults);
		// Read-only upper nibble must ignore the write
		wr(`CHG_REG_FAULT, 8'hF5);
		cyc(6);
		check("masked faults", 16'h000A, event_out.faults);
		rd_chk("fault reg masks", `CHG_REG_FAULT, 8'hF5);
		for (int i = 0; i < 3; i++) begin
			mb = 3'b001 << i;
			wr(`CHG_REG_THERM, {5'b00001, mb});
			cyc(6);
			check("event masks", {13'h0, ~mb}, {event_out.wake, event_out.reset, event_out.timer});
			check("monitor off", 16'h0000, ctrl_out.thermistor_monitor_enable);
		end
		wr(`CHG_REG_THERM, 8'h70);
		cyc(6);
		check("int content off", 16'h0000, ctrl_out.int_content_all);
		rd_chk("therm read only", `CHG_REG_THERM, {1'b0, status_in.temperature_fault_code,
			status_in.thermistor_open_flag, 4'h0});
		status_in <= '0;
		wr(`CHG_REG_FAULT, 8'h00);
		rd_chk("fault reg drained", `CHG_REG_FAULT, 8'hA0);
	endtask : t_masks

	task automatic t_current();
		logic [7:0] wv [5] = '{8'h9C, 8'h78, 8'hEC, 8'h06, 8'hFF};
		logic [7:0] rv [5] = '{8'h9C, 8'h78, 8'hE8, 8'h06, 8'hFF};
		logic [8:0] ma [5] = '{9'h06E, 9'h023, 9'h12C, 9'h006, 9'h000};
		for (int i = 0; i < 5; i++) begin
			if (i == 4) begin
				wr(8'h04, 8'h08);
			end
			wr(`CHG_REG_FAST, wv[i]);
			cyc(6);
			rd_chk("fast reg", `CHG_REG_FAST, rv[i]);
			check("current scale", rv[i][7], ctrl_out.charge_current_scale);
			check("current code", rv[i][6:2], ctrl_out.charge_current_code);
			check("external select", rv[i][6:2] == 5'h1F, ctrl_out.external_current_select);
			if (rv[i][6:2] != 5'h1F) begin
				check("charge current", ma[i], ctrl_out.charge_current_ma);
			end
			check("charger disable", rv[i][1], ctrl_out.charger_disable);
			check("high impedance", rv[i][0], ctrl_out.high_impedance_select);
		end
	endtask : t_current

	initial begin
		failures = 0;
		checks_done = 0;
		resetn = 1'b0;
		status_in = '0;
		strap_in = '0;
		strap_in.resistor_code = 5'h09;
		strap_in.otp_code = 5'h0C;
		t_reset_values();
		t_faults();
		t_masks();
		t_current();
		final_report();
	end

	// A hung transfer must still reach the verdict
	initial begin
		cyc(90000);
		failures++;
		$display("CHECK FAILED watchdog expected done seen running");
		final_report();
	end
endmodule : charger_fault_mask_charge_ctrl_regs_tb_top
